// >>> inc/flic_defs.vh
// Register offsets, field positions, reset values and encodings of the interrupt controller.
`ifndef FLIC_DEFS_VH
`define FLIC_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define FLIC_IDX_TCTRL     8'h88
`define FLIC_IDX_AUXPOL    8'ha1
`define FLIC_IDX_EN_MAIN   8'ha8
`define FLIC_IDX_EN_EXT    8'had
`define FLIC_IDX_PRI1_LO   8'hae
`define FLIC_IDX_PRI1_HI   8'haf
`define FLIC_IDX_PRI0_HI   8'hb7
`define FLIC_IDX_PRI0_LO   8'hb8
`define FLIC_IDX_X2CTRL    8'hc0

// Field positions of the timer and external interrupt control register.
`define FLIC_TC_EXT0_TYPE  0
`define FLIC_TC_EXT0_FLAG  1
`define FLIC_TC_EXT1_TYPE  2
`define FLIC_TC_EXT1_FLAG  3
`define FLIC_TC_T0_RUN     4
`define FLIC_TC_T0_FLAG    5
`define FLIC_TC_T1_RUN     6
`define FLIC_TC_T1_FLAG    7

// Field positions of the polarity and external interrupt 2 registers.
`define FLIC_AUX_EXT0_HI   0
`define FLIC_AUX_EXT1_HI   1
`define FLIC_X2_TYPE       0
`define FLIC_X2_FLAG       1
`define FLIC_X2_ENABLE     2
`define FLIC_X2_HI         3

// Global enable position and writable masks (reserved bits store nothing).
`define FLIC_EN_GLOBAL     7
`define FLIC_EN_MAIN_MASK  8'hbf
`define FLIC_EN_EXT_MASK   8'hef
`define FLIC_PRI0_MASK     8'h7f
`define FLIC_PRI1_MASK     8'hef
`define FLIC_AUX_MASK      8'h03
`define FLIC_X2_MASK       8'h0f
`define FLIC_REG_RESET     8'h00

// Source count, vector layout and source indices.
`define FLIC_NSRC          14
`define FLIC_VEC_BASE      16'h0003
`define FLIC_VEC_STRIDE    8
`define FLIC_SRC_EXT0      0
`define FLIC_SRC_T0        1
`define FLIC_SRC_EXT1      2
`define FLIC_SRC_T1        3
`define FLIC_SRC_EXT2      6

`endif

// >>> rtl/flic_top.v
// Four-level interrupt controller with APB register access.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
//
// Behaviour
// - fourteen sources, each with own enable bit
// - global enable bit 7 gates every request
// - main enable bits 0-5, bit 6 reserved
// - extended enables; external 2 enable elsewhere
// - two priority bits per source, four levels
// - lower level never preempts running routine
// - higher pending level is vectored first
// - fixed polling order breaks equal levels
// - flags sampled each cycle, polled next cycle
// - no call while equal/higher level active
// - call only on instruction's final cycle
// - after return or control write, one instruction
// - type bits choose level or edge sensing
// - polarity bits select high or rising
// - external flags set by hardware, edge auto-clear
// - external 2 polarity, enable, flag bit positions
// - external 2 wakes core only when enabled
// - external 2 type bit selects level/edge
// - software flag writes act like hardware
// - only external and timer flags auto-clear
`include "flic_defs.vh"

module flic_top (
	// APB slave.
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// External interrupt pins, asynchronous.
	input  wire        ext_irq_pin_0,
	input  wire        ext_irq_pin_1,
	input  wire        ext_irq_pin_2,
	// Peripheral request levels, same clock.
	input  wire        timer0_overflow,
	input  wire        timer1_overflow,
	input  wire        serial0_req,
	input  wire        timer2_req,
	input  wire        spi_req,
	input  wire        adc_req,
	input  wire        counter_array_req,
	input  wire        system_flag_req,
	input  wire        keypad_req,
	input  wire        two_wire0_req,
	input  wire        comparator0_req,
	// Core sequencer.
	input  wire        instr_last_cycle,
	input  wire        return_from_interrupt,
	input  wire        core_sleeping,
	output reg         hardware_subroutine_call,
	output reg  [15:0] irq_vector,
	output reg  [3:0]  irq_source,
	output wire        core_wakeup
);

	// Control and status registers.
	reg  [7:0]  timer_and_ext_irq_control;
	reg  [7:0]  auxiliary_polarity_control;
	reg  [7:0]  irq_enable_main;
	reg  [7:0]  extended_enable_reg;
	reg  [7:0]  priority0_low_bits;
	reg  [7:0]  priority0_high_bits;
	reg  [7:0]  priority1_low_bits;
	reg  [7:0]  priority1_high_bits;
	reg  [7:0]  ext_irq2_control;

	// Pin synchronisers and previous active levels.
	reg  [2:0]  pin_meta;
	reg  [2:0]  pin_sync;
	reg  [2:0]  pin_prev;

	// Sampled requests, active-level stack and post-write hold.
	reg  [13:0] req_sample;
	reg  [3:0]  active_levels;
	reg         vector_hold;
	wire        hold_set;

	wire        wr_en;
	wire        rd_setup;
	wire [9:0]  reg_idx;
	reg         addr_hit;
	reg  [7:0]  rd_value;
	wire [7:0]  wdat;

	wire [2:0]  pin_pol;
	wire [2:0]  pin_type;
	wire [2:0]  pin_active;
	wire [2:0]  prev_active;
	wire [2:0]  pin_edge;

	wire [13:0] src_flag;
	wire [13:0] src_enable;
	wire [13:0] pri_lo;
	wire [13:0] pri_hi;
	wire [13:0] src_request;

	reg         best_valid;
	reg  [1:0]  best_level;
	reg  [3:0]  best_idx;
	reg         level_free;
	reg         take_call;
	reg  [3:0]  next_active;
	reg         ret_done;
	integer     i;

	// Bus decode; the slave always answers in the first access cycle.
	assign pready   = 1'b1;
	assign wr_en    = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign reg_idx  = paddr[11:2];
	assign pslverr  = psel & penable & ~addr_hit;
	assign wdat     = pwdata[7:0];

	// Read mux; reserved bits read as zero because they are never stored.
	always @* begin
		addr_hit = 1'b1;
		rd_value = 8'h00;
		case (reg_idx)
			{2'b00, `FLIC_IDX_TCTRL}:   rd_value = timer_and_ext_irq_control;
			{2'b00, `FLIC_IDX_AUXPOL}:  rd_value = auxiliary_polarity_control;
			{2'b00, `FLIC_IDX_EN_MAIN}: rd_value = irq_enable_main;
			{2'b00, `FLIC_IDX_EN_EXT}:  rd_value = extended_enable_reg;
			{2'b00, `FLIC_IDX_PRI1_LO}: rd_value = priority1_low_bits;
			{2'b00, `FLIC_IDX_PRI1_HI}: rd_value = priority1_high_bits;
			{2'b00, `FLIC_IDX_PRI0_HI}: rd_value = priority0_high_bits;
			{2'b00, `FLIC_IDX_PRI0_LO}: rd_value = priority0_low_bits;
			{2'b00, `FLIC_IDX_X2CTRL}:  rd_value = ext_irq2_control;
			default:                    addr_hit = 1'b0;
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flip-flop.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= {24'h000000, rd_value};
		end
	end

	// Two flip-flops before any logic looks at the pins.
	// They reset high, the idle level of the pins, so no false edge follows reset.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 3'h7;
			pin_sync <= 3'h7;
			pin_prev <= 3'h7;
		end else begin
			pin_meta <= {ext_irq_pin_2, ext_irq_pin_1, ext_irq_pin_0};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Polarity and type per pin; default sensing is low level or falling edge.
	assign pin_pol     = {ext_irq2_control[`FLIC_X2_HI],
	                      auxiliary_polarity_control[`FLIC_AUX_EXT1_HI],
	                      auxiliary_polarity_control[`FLIC_AUX_EXT0_HI]};
	assign pin_type    = {ext_irq2_control[`FLIC_X2_TYPE],
	                      timer_and_ext_irq_control[`FLIC_TC_EXT1_TYPE],
	                      timer_and_ext_irq_control[`FLIC_TC_EXT0_TYPE]};
	assign pin_active  = ~(pin_sync ^ pin_pol);
	assign prev_active = ~(pin_prev ^ pin_pol);
	assign pin_edge    = pin_active & ~prev_active;

	// Per-source flags, enables and priority bits in polling order.
	assign src_flag = {comparator0_req, two_wire0_req, keypad_req, system_flag_req,
	                   counter_array_req, adc_req, spi_req,
	                   ext_irq2_control[`FLIC_X2_FLAG],
	                   timer2_req, serial0_req,
	                   timer_and_ext_irq_control[`FLIC_TC_T1_FLAG],
	                   timer_and_ext_irq_control[`FLIC_TC_EXT1_FLAG],
	                   timer_and_ext_irq_control[`FLIC_TC_T0_FLAG],
	                   timer_and_ext_irq_control[`FLIC_TC_EXT0_FLAG]};
	assign src_enable = {extended_enable_reg[7:5], extended_enable_reg[3:0],
	                     ext_irq2_control[`FLIC_X2_ENABLE],
	                     irq_enable_main[5:0]};
	assign pri_lo = {priority1_low_bits[7:5], priority1_low_bits[3:0],
	                 priority0_low_bits[6:0]};
	assign pri_hi = {priority1_high_bits[7:5], priority1_high_bits[3:0],
	                 priority0_high_bits[6:0]};

	// Each request is gated by its own enable and by the global enable.
	genvar g;
	generate
		for (g = 0; g < `FLIC_NSRC; g = g + 1) begin : gen_req
			assign src_request[g] = src_flag[g] & src_enable[g]
			                        & irq_enable_main[`FLIC_EN_GLOBAL];
		end
	endgenerate

	// Sample every cycle; the poll below works on last cycle's sample.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_sample <= 14'h0000;
		end else begin
			req_sample <= src_request;
		end
	end

	// Poll: highest level wins, lowest index wins within a level.
	// Scanning downwards with >= lets the lower index take a tie.
	always @* begin
		best_valid = 1'b0;
		best_level = 2'b00;
		best_idx   = 4'h0;
		for (i = `FLIC_NSRC - 1; i >= 0; i = i - 1) begin
			if (req_sample[i] && (!best_valid || {pri_hi[i], pri_lo[i]} >= best_level)) begin
				best_valid = 1'b1;
				best_level = {pri_hi[i], pri_lo[i]};
				best_idx   = i[3:0];
			end
		end
	end

	// A call needs a free level above anything in service, the last
	// instruction cycle, and no pending hold from a return or control write.
	always @* begin
		level_free = 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			if (active_levels[i] && i[1:0] >= best_level) begin
				level_free = 1'b0;
			end
		end
		take_call = best_valid & level_free & instr_last_cycle & ~vector_hold & ~hold_set;
	end

	// Return pops the highest level in service; a call pushes its level.
	always @* begin
		next_active = active_levels;
		ret_done    = 1'b0;
		if (return_from_interrupt) begin
			for (i = 3; i >= 0; i = i - 1) begin
				if (active_levels[i] && !ret_done) begin
					next_active[i] = 1'b0;
					ret_done       = 1'b1;
				end
			end
		end
		if (take_call) begin
			next_active[best_level] = 1'b1;
		end
	end

	// Call outputs and in-service tracking.
	// Source and vector keep their last values so the core may read them late.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_levels            <= 4'h0;
			hardware_subroutine_call <= 1'b0;
			irq_vector               <= 16'h0000;
			irq_source               <= 4'h0;
		end else begin
			active_levels            <= next_active;
			hardware_subroutine_call <= take_call;
			if (take_call) begin
				irq_source <= best_idx;
				irq_vector <= `FLIC_VEC_BASE
				              + {9'h000, best_idx, 3'h0};
			end
		end
	end

	// A return or a control write in this very cycle blocks the call too.
	// The hold register only covers the cycles after it, so without this
	// term a request could vector inside the blocking instruction itself.
	assign hold_set = return_from_interrupt
	                  | (wr_en & addr_hit
	                     & (reg_idx != {2'b00, `FLIC_IDX_TCTRL})
	                     & (reg_idx != {2'b00, `FLIC_IDX_AUXPOL}));

	// The hold covers the instruction doing the return or the control write,
	// so the one after it always runs before any vectoring; set beats clear.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_hold <= 1'b0;
		end else if (hold_set) begin
			vector_hold <= 1'b1;
		end else if (instr_last_cycle) begin
			vector_hold <= 1'b0;
		end
	end

	// Plain control registers; reserved bits are masked off so they stay zero.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auxiliary_polarity_control <= `FLIC_REG_RESET;
			irq_enable_main            <= `FLIC_REG_RESET;
			extended_enable_reg        <= `FLIC_REG_RESET;
			priority0_low_bits         <= `FLIC_REG_RESET;
			priority0_high_bits        <= `FLIC_REG_RESET;
			priority1_low_bits         <= `FLIC_REG_RESET;
			priority1_high_bits        <= `FLIC_REG_RESET;
		end else if (wr_en) begin
			case (reg_idx)
				{2'b00, `FLIC_IDX_AUXPOL}:  auxiliary_polarity_control <= wdat & `FLIC_AUX_MASK;
				{2'b00, `FLIC_IDX_EN_MAIN}: irq_enable_main <= wdat & `FLIC_EN_MAIN_MASK;
				{2'b00, `FLIC_IDX_EN_EXT}:  extended_enable_reg <= wdat & `FLIC_EN_EXT_MASK;
				{2'b00, `FLIC_IDX_PRI1_LO}: priority1_low_bits <= wdat & `FLIC_PRI1_MASK;
				{2'b00, `FLIC_IDX_PRI1_HI}: priority1_high_bits <= wdat & `FLIC_PRI1_MASK;
				{2'b00, `FLIC_IDX_PRI0_HI}: priority0_high_bits <= wdat & `FLIC_PRI0_MASK;
				{2'b00, `FLIC_IDX_PRI0_LO}: priority0_low_bits <= wdat & `FLIC_PRI0_MASK;
				default: ;
			endcase
		end
	end

	// Flag logic: software write first, then vectoring clear, then hardware
	// set, so an event in the clearing cycle is never lost.
	reg [7:0] next_tctrl;
	reg [7:0] next_x2;
	always @* begin
		next_tctrl = timer_and_ext_irq_control;
		next_x2    = ext_irq2_control;
		if (wr_en && reg_idx == {2'b00, `FLIC_IDX_TCTRL}) begin
			next_tctrl = wdat;
		end
		if (wr_en && reg_idx == {2'b00, `FLIC_IDX_X2CTRL}) begin
			next_x2 = wdat & `FLIC_X2_MASK;
		end
		// Only the external and timer 0/1 flags are cleared by vectoring.
		if (take_call) begin
			case (best_idx)
				`FLIC_SRC_EXT0: if (pin_type[0]) next_tctrl[`FLIC_TC_EXT0_FLAG] = 1'b0;
				`FLIC_SRC_T0:   next_tctrl[`FLIC_TC_T0_FLAG] = 1'b0;
				`FLIC_SRC_EXT1: if (pin_type[1]) next_tctrl[`FLIC_TC_EXT1_FLAG] = 1'b0;
				`FLIC_SRC_T1:   next_tctrl[`FLIC_TC_T1_FLAG] = 1'b0;
				`FLIC_SRC_EXT2: if (pin_type[2]) next_x2[`FLIC_X2_FLAG] = 1'b0;
				default: ;
			endcase
		end
		// Level mode tracks the pin; edge mode latches the detected edge.
		next_tctrl[`FLIC_TC_EXT0_FLAG] = pin_type[0]
			? (next_tctrl[`FLIC_TC_EXT0_FLAG] | pin_edge[0]) : pin_active[0];
		next_tctrl[`FLIC_TC_EXT1_FLAG] = pin_type[1]
			? (next_tctrl[`FLIC_TC_EXT1_FLAG] | pin_edge[1]) : pin_active[1];
		next_x2[`FLIC_X2_FLAG] = pin_type[2]
			? (next_x2[`FLIC_X2_FLAG] | pin_edge[2]) : pin_active[2];
		if (timer0_overflow) begin
			next_tctrl[`FLIC_TC_T0_FLAG] = 1'b1;
		end
		if (timer1_overflow) begin
			next_tctrl[`FLIC_TC_T1_FLAG] = 1'b1;
		end
	end

	// Flag-bearing registers.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_and_ext_irq_control <= `FLIC_REG_RESET;
			ext_irq2_control          <= `FLIC_REG_RESET;
		end else begin
			timer_and_ext_irq_control <= next_tctrl;
			ext_irq2_control          <= next_x2;
		end
	end

	// Wake-up ignores the global enable but needs the external 2 enable.
	// Limitation: it is a level and stays high until the flag is cleared.
	assign core_wakeup = core_sleeping & ext_irq2_control[`FLIC_X2_FLAG]
	                     & ext_irq2_control[`FLIC_X2_ENABLE];

endmodule // flic_top

// >>> sim/flic_props.sv
// Concurrent checks on the ports of the interrupt controller.
`timescale 1ns/1ps
`include "flic_defs.vh"
module flic_props (
	// Clock, reset and register bus.
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	// Core sequencer side.
	input wire        instr_last_cycle,
	input wire        return_from_interrupt,
	input wire        core_sleeping,
	input wire        hardware_subroutine_call,
	input wire [15:0] irq_vector,
	input wire [3:0]  irq_source,
	input wire        core_wakeup
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Read access phase of one register, and the call pulse itself.
	sequence s_rd(idx);
		psel && penable && !pwrite && paddr[11:2] == idx;
	endsequence
	sequence s_call;
		hardware_subroutine_call;
	endsequence
	// Write access phase to a register whose write delays vectoring.
	sequence s_ctl_wr;
		psel && penable && pwrite && (paddr[11:2] inside {`FLIC_IDX_EN_MAIN, `FLIC_IDX_EN_EXT,
			`FLIC_IDX_PRI1_LO, `FLIC_IDX_PRI1_HI, `FLIC_IDX_PRI0_HI, `FLIC_IDX_PRI0_LO,
			`FLIC_IDX_X2CTRL});
	endsequence

	AST_CALL_PULSE: assert property (s_call |=> !hardware_subroutine_call)
		else $error("call pulse longer than one cycle");
	AST_VEC_MAP: assert property (s_call |-> irq_vector == 16'h0003 + {irq_source, 3'b000})
		else $error("vector does not match source");
	AST_SRC_RANGE: assert property (s_call |-> irq_source < 4'he)
		else $error("source index out of range");
	AST_LAST_CYCLE: assert property (s_call |-> $past(instr_last_cycle))
		else $error("call not polled on final instruction cycle");
	AST_RETURN_BLOCK: assert property (s_call |-> !$past(return_from_interrupt))
		else $error("call polled during a return instruction");
	AST_CTRL_WR_BLOCK: assert property (s_ctl_wr |=> !hardware_subroutine_call)
		else $error("call vectored inside a control register write");
	AST_WAKE: assert property (core_wakeup |-> core_sleeping)
		else $error("wake-up while core awake");
	AST_EN_RSV: assert property (s_rd(`FLIC_IDX_EN_MAIN) |-> prdata[6] == 1'b0)
		else $error("reserved enable bit reads set");
	AST_X2_RSV: assert property (s_rd(`FLIC_IDX_X2CTRL) |-> prdata[7:4] == 4'h0)
		else $error("reserved ext2 control bits read set");
endmodule // flic_props

bind flic_top flic_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.instr_last_cycle, .return_from_interrupt, .core_sleeping, .hardware_subroutine_call,
	.irq_vector, .irq_source, .core_wakeup);

// >>> sim/flic_core_model.sv
// Core sequencer model: instruction boundaries, return pulses and sleep.
`timescale 1ns/1ps
module flic_core_model (
	// Clock and reset.
	input  wire pclk,
	input  wire presetn,
	// Requests from the bench.
	input  wire ret_req,
	input  wire sleep_req,
	// Sequencer outputs.
	output reg  instr_last_cycle,
	output reg  return_from_interrupt,
	output wire core_sleeping
);
	reg [1:0] cnt;
	reg       ret_q;
	reg       pend;

	assign core_sleeping = sleep_req;

	// Three-cycle instructions; a return is only ever seen on its own final cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 2'h0;
			ret_q <= 1'b0;
			pend <= 1'b0;
			instr_last_cycle <= 1'b0;
			return_from_interrupt <= 1'b0;
		end else begin
			cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
			instr_last_cycle <= (cnt == 2'h1);
			ret_q <= ret_req;
			return_from_interrupt <= (cnt == 2'h1) && (pend || (ret_req && !ret_q));
			pend <= (pend || (ret_req && !ret_q)) && (cnt != 2'h1);
		end
	end
endmodule // flic_core_model

// >>> sim/flic_top_tb_top.sv
// Self-checking bench of the four-level interrupt controller.
`timescale 1ns/1ps
`include "flic_defs.vh"
module flic_top_tb_top;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	reg         ext_irq_pin_0 = 1'b1;
	reg         ext_irq_pin_1 = 1'b1;
	reg         ext_irq_pin_2 = 1'b1;
	reg         timer0_overflow = 1'b0;
	reg         timer1_overflow = 1'b0;
	reg  [8:0]  prq = 9'h000;
	reg         ret_req = 1'b0;
	reg         sleep_req = 1'b0;
	wire [31:0] prdata;
	wire        pready, pslverr, instr_last_cycle, return_from_interrupt, core_sleeping;
	wire        hardware_subroutine_call, core_wakeup;
	wire [15:0] irq_vector;
	wire [3:0]  irq_source;
	reg  [31:0] rdv;
	reg         erv;
	integer     n_errors = 0;
	integer     checks_done = 0;
	reg  [7:0]  ix [0:8];

	always #4 pclk = ~pclk;

	flic_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ext_irq_pin_0, .ext_irq_pin_1, .ext_irq_pin_2, .timer0_overflow,
		.timer1_overflow, .serial0_req(prq[0]), .timer2_req(prq[1]), .spi_req(prq[2]),
		.adc_req(prq[3]), .counter_array_req(prq[4]), .system_flag_req(prq[5]),
		.keypad_req(prq[6]), .two_wire0_req(prq[7]), .comparator0_req(prq[8]),
		.instr_last_cycle, .return_from_interrupt, .core_sleeping, .hardware_subroutine_call,
		.irq_vector, .irq_source, .core_wakeup);
	flic_core_model core (.pclk, .presetn, .ret_req, .sleep_req, .instr_last_cycle,
		.return_from_interrupt, .core_sleeping);

	task conclude;
		begin
			$display("checks %0d mismatches %0d", checks_done, n_errors);
			if (n_errors == 0 && checks_done > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [31:0] e, input [31:0] g, input string nm);
		begin
			checks_done++;
			if (e !== g) begin
				n_errors++;
				$display("unexpected %s: expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// One APB transfer; the request stands until pready is sampled high.
	task apb(input w, input [7:0] i, input [7:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= {2'b00, i, 2'b00};
			pwdata <= {24'h0, d};
			@(posedge pclk);
			penable <= 1'b1;
			do @(posedge pclk); while (pready !== 1'b1);
			rdv = prdata;
			erv = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rd(input [7:0] i, input [7:0] e);
		begin apb(1'b0, i, 8'h00); chk({24'h0, e}, rdv, "register"); end
	endtask
	task wr(input [7:0] i, input [7:0] d);
		begin apb(1'b1, i, d); end
	endtask
	// Waits a bounded time for a call and judges its source and vector.
	task call(input [3:0] s);
		integer k;
		begin
			k = 0;
			do begin @(posedge pclk); k++; end while (hardware_subroutine_call !== 1'b1 && k < 60);
			chk(1, hardware_subroutine_call, "call");
			chk(s, irq_source, "source");
			chk(16'h0003 + 8 * s, irq_vector, "vector");
		end
	endtask
	task no_call(input integer n);
		begin
			repeat (n) begin @(posedge pclk); if (hardware_subroutine_call !== 1'b0) chk(0, 1, "call"); end
			chk(0, 0, "quiet");
		end
	endtask
	task ret;
		begin ret_req <= 1'b1; @(posedge pclk); ret_req <= 1'b0; end
	endtask

	// Reset values, unmapped access and read-back of main enable and external 2 control.
	task t_regs;
		integer i;
		begin
			for (i = 0; i < 9; i++) rd(ix[i], 8'h00);
			apb(1'b0, 8'h00, 8'h00);
			chk(1, erv, "pslverr");
			wr(`FLIC_IDX_EN_MAIN, 8'hbf);
			rd(`FLIC_IDX_EN_MAIN, 8'hbf);
			wr(`FLIC_IDX_X2CTRL, 8'h04);
			rd(`FLIC_IDX_X2CTRL, 8'h04);
			wr(`FLIC_IDX_X2CTRL, 8'h00);
		end
	endtask
	// Every source but external 2 enabled with the global bit clear, all nine peripheral requests raised.
	task t_global;
		begin
			wr(`FLIC_IDX_EN_EXT, 8'hef);
			wr(`FLIC_IDX_EN_MAIN, 8'h3f);
			prq <= 9'h1ff;
			no_call(40);
			prq <= 9'h000;
			wr(`FLIC_IDX_EN_MAIN, 8'h00);
		end
	endtask
	// Higher level first, no preemption by the lower one, then the lower one.
	task t_prio;
		begin
			wr(`FLIC_IDX_PRI1_HI, 8'h02);
			wr(`FLIC_IDX_PRI1_LO, 8'h02);
			wr(`FLIC_IDX_EN_EXT, 8'h03);
			wr(`FLIC_IDX_EN_MAIN, 8'h80);
			prq <= 9'h00c;
			call(4'd8);
			prq <= 9'h004;
			no_call(30);
			ret;
			call(4'd7);
			prq <= 9'h000;
			ret;
			wr(`FLIC_IDX_EN_EXT, 8'h00);
		end
	endtask
	// Both timers at one level: polling order, blocking, flag auto-clear.
	task t_tmr;
		begin
			wr(`FLIC_IDX_EN_MAIN, 8'h8a);
			@(posedge pclk);
			timer0_overflow <= 1'b1;
			timer1_overflow <= 1'b1;
			@(posedge pclk);
			timer0_overflow <= 1'b0;
			timer1_overflow <= 1'b0;
			call(4'd1);
			no_call(20);
			ret;
			call(4'd3);
			ret;
			rd(`FLIC_IDX_TCTRL, 8'h00);
		end
	endtask
	// Middle levels: code 10 outranks code 01 whatever the index.
	task t_lvl;
		begin
			wr(`FLIC_IDX_PRI0_HI, 8'h08);
			wr(`FLIC_IDX_PRI0_LO, 8'h02);
			wr(`FLIC_IDX_EN_MAIN, 8'h8a);
			timer0_overflow <= 1'b1;
			timer1_overflow <= 1'b1;
			@(posedge pclk);
			timer0_overflow <= 1'b0;
			timer1_overflow <= 1'b0;
			call(4'd3);
			no_call(20);
			ret;
			call(4'd1);
			ret;
			wr(`FLIC_IDX_PRI0_HI, 8'h00);
			wr(`FLIC_IDX_PRI0_LO, 8'h00);
			wr(`FLIC_IDX_EN_MAIN, 8'h00);
		end
	endtask
	// Edge types, rising polarity and a flag raised by software.
	task t_ext;
		begin
			wr(`FLIC_IDX_TCTRL, 8'h05);
			wr(`FLIC_IDX_AUXPOL, 8'h02);
			wr(`FLIC_IDX_EN_MAIN, 8'h85);
			ext_irq_pin_0 <= 1'b0;
			call(4'd0);
			ret;
			rd(`FLIC_IDX_TCTRL, 8'h05);
			ext_irq_pin_1 <= 1'b0;
			no_call(20);
			ext_irq_pin_1 <= 1'b1;
			call(4'd2);
			ret;
			wr(`FLIC_IDX_TCTRL, 8'h0d);
			call(4'd2);
			ret;
			ext_irq_pin_0 <= 1'b1;
			wr(`FLIC_IDX_EN_MAIN, 8'h00);
			wr(`FLIC_IDX_TCTRL, 8'h00);
			wr(`FLIC_IDX_AUXPOL, 8'h00);
		end
	endtask
	// External 2 wakes a sleeping core only while enabled.
	task t_wake;
		begin
			sleep_req <= 1'b1;
			wr(`FLIC_IDX_X2CTRL, 8'h05);
			ext_irq_pin_2 <= 1'b0;
			repeat (10) @(posedge pclk);
			chk(1, core_wakeup, "wakeup");
			sleep_req <= 1'b0;
			@(posedge pclk);
			chk(0, core_wakeup, "wakeup awake");
			sleep_req <= 1'b1;
			wr(`FLIC_IDX_X2CTRL, 8'h01);
			ext_irq_pin_2 <= 1'b1;
			repeat (6) @(posedge pclk);
			ext_irq_pin_2 <= 1'b0;
			repeat (10) @(posedge pclk);
			chk(0, core_wakeup, "wakeup");
			rd(`FLIC_IDX_X2CTRL, 8'h03);
			wr(`FLIC_IDX_X2CTRL, 8'h00);
			rd(`FLIC_IDX_X2CTRL, 8'h02);
			ext_irq_pin_2 <= 1'b1;
			repeat (4) @(posedge pclk);
			rd(`FLIC_IDX_X2CTRL, 8'h00);
			sleep_req <= 1'b0;
		end
	endtask

	// Watchdog: the whole sequence needs a few hundred cycles.
	initial begin
		#(8 * 20000);
		n_errors++;
		conclude;
	end
	initial begin
		ix[0] = `FLIC_IDX_TCTRL;
		ix[1] = `FLIC_IDX_AUXPOL;
		ix[2] = `FLIC_IDX_EN_MAIN;
		ix[3] = `FLIC_IDX_EN_EXT;
		ix[4] = `FLIC_IDX_PRI1_LO;
		ix[5] = `FLIC_IDX_PRI1_HI;
		ix[6] = `FLIC_IDX_PRI0_HI;
		ix[7] = `FLIC_IDX_PRI0_LO;
		ix[8] = `FLIC_IDX_X2CTRL;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_global;
		t_prio;
		t_tmr;
		t_lvl;
		t_ext;
		t_wake;
		conclude;
	end
endmodule // flic_top_tb_top
